// ### inc/tse_pkg.sv
// Shared constants and types of the texture sampling engine
package tse_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam int ID_W = 4;
  localparam int CW = 16;
  localparam int CO_W = 20;
  localparam int FRAC_W = 4;
  localparam int WSHIFT = 12;
  localparam int PAL_AW = 8;
  localparam int SS_STRIDE_SH = 2;
  localparam int FACE_SH = 4;
  localparam int CUBE_SH = 11;

  // Filter weights: spatial out of 256, level out of 16, total 4096
  localparam logic [9:0] SW_FULL = 10'h100;
  localparam logic [9:0] SW_BOX = 10'h004;
  localparam logic [4:0] LW_FULL = 5'h10;
  localparam logic [4:0] FR_ONE = 5'h10;
  localparam logic [12:0] W_FULL = 13'h1000;
  localparam logic [CO_W-1:0] HALF_TEXEL = 20'h00008;
  localparam logic [CW-1:0] CUBE_ONE = 16'h4000;
  localparam logic [4:0] MAX_LOD = 5'h0D;
  localparam logic [5:0] LAST_BILIN = 6'h03;
  localparam logic [5:0] LAST_SCALE = 6'h3F;
  localparam logic [CO_W-1:0] SCALE_OFF = 20'h00003;
  localparam logic [5:0] BASE_TUPLES = 6'h08;

  // Filter configuration word fields
  localparam int SS_FILT = 0;
  localparam int SS_MIPLIN = 2;
  localparam int SS_ADDRU = 3;
  localparam int SS_ADDRV = 5;
  localparam int SS_GAMMA = 7;
  localparam int SS_SHADOW = 8;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {MSG_SAMPLE, MSG_LD, MSG_BUF_LD} tse_msg_e;
  typedef enum logic [1:0] {SIMD8, SIMD16, SIMD32, SIMD64} tse_simd_e;
  typedef enum logic [1:0] {FMT_RGBA8, FMT_RGBA4, FMT_PAL8} tse_fmt_e;
  typedef enum logic [1:0] {FILT_NEAREST, FILT_BILINEAR, FILT_SCALE8}
    tse_filt_e;
  typedef enum logic [1:0] {ADDR_WRAP, ADDR_CLAMP, ADDR_MIRROR} tse_addr_e;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] mip_pitch;
    logic [3:0] w_log2;
    logic [3:0] h_log2;
    tse_fmt_e fmt;
    logic cube;
  } tse_surf_s;

  typedef struct packed {
    logic [ID_W-1:0] id;
    tse_msg_e msg;
    tse_simd_e simd;
    logic [31:0] ss_ptr;
    logic [3:0] ss_idx;
    tse_surf_s surf;
    logic lod_given;
    logic [7:0] lod;
    logic [CW-1:0] grad;
    logic [CW-1:0] u;
    logic [CW-1:0] v;
    logic [CW-1:0] r;
    logic rt_en;
    logic [31:0] rt_base;
  } tse_req_s;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [5:0] tuple;
    logic [3:0] subspan;
    logic [1:0] lane;
    logic last;
    logic [31:0] rgba;
  } tse_res_s;

endpackage

// ### hw/tse_palette_ram.sv
// Texture palette memory with registered read data
module tse_palette_ram #(
  parameter int DW = 32,
  parameter int AW = 8
) (
  input wire logic clk_i,          // Clock
  input wire logic we_i,           // Write strobe
  input wire logic [AW-1:0] waddr_i, // Write index
  input wire logic [DW-1:0] wdata_i, // Write colour
  input wire logic [AW-1:0] raddr_i, // Read index
  output logic [DW-1:0] rdata_o    // Colour, one cycle after index
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// ### hw/tse_sampler.sv
// Texture sampling engine: one tuple at a time, one memory access in flight
//
// Behaviour
// - Index picks one of sixteen filter configurations
// - Load messages run without filter configuration
// - Surface location, size, format from descriptor
// - Result to requester or render target
// - All 8/16/32/64 tuples processed alike
// - Narrow tuples grouped into 2x2 subspans
// - Eight-wide two subspans, sixteen-wide four
// - Fetch texels itself, may cache data
// - Given or computed LOD selects mip
// - Cube face chosen before address generation
// - Wrap/clamp/mirror, LOD, sample and level weights
// - Fetch, decompress, convert to internal form
// - Paletted indices looked up in palette
// - Shadow compare against third coordinate
// - Weighted filter yields one four-component texel
// - Gamma linearization on RGB, never alpha
// - Eight-by-eight video scaling kernel
// - Untyped buffer loads accepted
module tse_sampler (
  input wire logic clk_i,                   // Clock, 125 MHz
  input wire logic resetn_i,                // Async reset, active low
  input wire logic req_valid_i,             // Tuple offered
  output logic req_ready_o,                 // Tuple accepted when high
  input wire tse_pkg::tse_req_s req_i,      // Tuple with message header
  output logic mem_req_valid_o,             // Memory access offered
  input wire logic mem_req_ready_i,         // Memory access taken
  output logic mem_req_we_o,                // Write when high
  output logic [31:0] mem_req_addr_o,       // Byte address
  output logic [31:0] mem_req_wdata_o,      // Write data
  input wire logic mem_rsp_valid_i,         // Read data valid
  input wire logic [31:0] mem_rsp_data_i,   // Read data
  input wire logic pal_we_i,                // Palette load strobe
  input wire logic [7:0] pal_addr_i,        // Palette load index
  input wire logic [31:0] pal_data_i,       // Palette load colour
  output logic res_valid_o,                 // Result offered
  input wire logic res_ready_i,             // Result taken
  output tse_pkg::tse_res_s res_o           // Result
);
  import tse_pkg::*;

  typedef enum {ST_IDLE, ST_SS_REQ, ST_SS_WAIT, ST_SETUP, ST_F_REQ,
    ST_F_WAIT, ST_PAL, ST_ACC, ST_OUT} tse_state_e;

  function automatic logic [7:0] lod_of(input logic [CW-1:0] g);
    logic [7:0] r;
    logic [CW-1:0] n;
    r = 8'h00;
    n = '0;
    for (int i = FRAC_W; i < CW; i++) begin
      if (g[i]) begin
        n = g << (CW - 1 - i);
        r = {4'(i - FRAC_W), n[CW-2 -: 4]};
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] addr_ctl(input logic signed [CO_W-1:0] c,
      input logic [3:0] wl, input tse_addr_e m);
    logic [CO_W-1:0] w;
    logic [CO_W-1:0] mm;
    logic [13:0] r;
    w = 20'h00001 << wl;
    mm = c & ((w << 1) - 20'h00001);
    case (m)
      ADDR_WRAP: r = 14'(c & (w - 20'h00001));
      ADDR_MIRROR: r = 14'((mm >= w) ? ((w << 1) - 20'h00001 - mm) : mm);
      default: r = c[CO_W-1] ? 14'h0000 :
        (c >= signed'(w)) ? 14'(w - 20'h00001) : 14'(c);
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  tse_state_e state;
  tse_req_s cur;
  logic [31:0] ss;
  logic ss_valid;
  logic [35:0] ss_key;
  logic [5:0] tuple_cnt;
  logic [5:0] samp;
  logic pass;
  logic [7:0] lod;
  logic [2:0] face;
  logic signed [CO_W-1:0] s_co;
  logic signed [CO_W-1:0] t_co;
  logic [31:0] word;
  logic [31:0] pal_rdata;
  logic [31:0] rgba_w;

  // Effective sampling controls; loads ignore the configuration
  wire samp_msg = cur.msg == MSG_SAMPLE;
  wire buf_msg = cur.msg == MSG_BUF_LD;
  tse_filt_e filt;
  tse_addr_e mode_u;
  tse_addr_e mode_v;
  assign filt = samp_msg ? tse_filt_e'(ss[SS_FILT +: 2]) : FILT_NEAREST;
  assign mode_u = samp_msg ? tse_addr_e'(ss[SS_ADDRU +: 2]) : ADDR_CLAMP;
  assign mode_v = samp_msg ? tse_addr_e'(ss[SS_ADDRV +: 2]) : ADDR_CLAMP;
  wire miplin = samp_msg && ss[SS_MIPLIN];
  wire use_gamma = samp_msg && ss[SS_GAMMA];
  wire use_shadow = samp_msg && ss[SS_SHADOW];
  wire lin = filt == FILT_BILINEAR;
  wire scale = filt == FILT_SCALE8;

  wire [35:0] key_in = {req_i.ss_ptr, req_i.ss_idx};
  wire need_ss = req_i.msg == MSG_SAMPLE && !(ss_valid && ss_key == key_in);
  wire [31:0] ss_addr = cur.ss_ptr + (32'(cur.ss_idx) << SS_STRIDE_SH);

  ////////////////////////////////////////////////////////////////////////
  // Cube face selection on setup; coordinates arrive pre-divided
  wire [CW-1:0] au = cur.u[CW-1] ? -cur.u : cur.u;
  wire [CW-1:0] av = cur.v[CW-1] ? -cur.v : cur.v;
  wire [CW-1:0] ar = cur.r[CW-1] ? -cur.r : cur.r;
  wire maj_x = au >= av && au >= ar;
  wire maj_y = !maj_x && av >= ar;
  wire [2:0] face_w = maj_x ? {2'h0, cur.u[CW-1]} :
    maj_y ? {2'h1, cur.v[CW-1]} : {2'h2, cur.r[CW-1]};
  wire [CW-1:0] cs = maj_x ? cur.v : cur.u;
  wire [CW-1:0] ct = (maj_x || maj_y) ? cur.r : cur.v;
  wire [16:0] cs1 = {cs[CW-1], cs} + {1'b0, CUBE_ONE};
  wire [16:0] ct1 = {ct[CW-1], ct} + {1'b0, CUBE_ONE};
  wire [29:0] cs_sc = ({13'h0000, cs1} << cur.surf.w_log2) >> CUBE_SH;
  wire [29:0] ct_sc = ({13'h0000, ct1} << cur.surf.h_log2) >> CUBE_SH;
  wire [CO_W-1:0] s_in = cur.surf.cube ? cs_sc[CO_W-1:0] :
    {{(CO_W-CW){cur.u[CW-1]}}, cur.u};
  wire [CO_W-1:0] t_in = cur.surf.cube ? ct_sc[CO_W-1:0] :
    {{(CO_W-CW){cur.v[CW-1]}}, cur.v};
  wire [7:0] lod_in = cur.lod_given ? cur.lod : lod_of(cur.grad);

  ////////////////////////////////////////////////////////////////////////
  // Texel address of the current sample and level
  wire [4:0] lvl_raw = {1'b0, lod[7:4]} + {4'h0, pass};
  wire [3:0] lvl = (lvl_raw > MAX_LOD) ? MAX_LOD[3:0] : lvl_raw[3:0];
  wire [3:0] wl = (cur.surf.w_log2 > lvl) ? cur.surf.w_log2 - lvl : 4'h0;
  wire [3:0] hl = (cur.surf.h_log2 > lvl) ? cur.surf.h_log2 - lvl : 4'h0;
  // Kept signed so that negative coordinates shift arithmetically
  wire signed [CO_W-1:0] half_off = lin ? HALF_TEXEL : '0;
  wire signed [CO_W-1:0] s_sh = (s_co >>> lvl) - half_off;
  wire signed [CO_W-1:0] t_sh = (t_co >>> lvl) - half_off;
  wire [3:0] fx = s_sh[FRAC_W-1:0];
  wire [3:0] fy = t_sh[FRAC_W-1:0];
  logic signed [CO_W-1:0] dx;
  logic signed [CO_W-1:0] dy;
  assign dx = scale ? CO_W'(samp[2:0]) - SCALE_OFF :
    CO_W'(lin && samp[0]);
  assign dy = scale ? CO_W'(samp[5:3]) - SCALE_OFF :
    CO_W'(lin && samp[1]);
  wire [13:0] xa = addr_ctl((s_sh >>> FRAC_W) + dx, wl, mode_u);
  wire [13:0] ya = addr_ctl((t_sh >>> FRAC_W) + dy, hl, mode_v);
  wire [27:0] t_idx = ({14'h0000, ya} << wl) | {14'h0000, xa};
  wire [27:0] w_idx = (cur.surf.fmt == FMT_RGBA4) ? t_idx >> 1 :
    (cur.surf.fmt == FMT_PAL8) ? t_idx >> 2 : t_idx;
  wire [31:0] lvl_off = 32'(lvl * cur.surf.mip_pitch);
  wire [31:0] face_off = cur.surf.cube ?
    32'(face * (cur.surf.mip_pitch << FACE_SH)) : '0;
  wire [31:0] fetch_addr = buf_msg ? cur.surf.base + {14'h0000, cur.u, 2'h0} :
    cur.surf.base + lvl_off + face_off + {2'h0, w_idx, 2'h0};
  wire [31:0] rt_addr = cur.rt_base + {24'h000000, tuple_cnt, 2'h0};

  ////////////////////////////////////////////////////////////////////////
  // Texel decode and weights
  wire [15:0] half = t_idx[0] ? word[31:16] : word[15:0];
  wire [31:0] rgba4 = {half[15:12], half[15:12], half[11:8], half[11:8],
    half[7:4], half[7:4], half[3:0], half[3:0]};
  wire [7:0] pal_idx = word[8*t_idx[1:0] +: 8];
  wire [31:0] texel = buf_msg ? word :
    (cur.surf.fmt == FMT_RGBA4) ? rgba4 :
    (cur.surf.fmt == FMT_PAL8) ? pal_rdata : word;
  wire shadow_pass = texel[7:0] <= cur.r[CW-1 -: 8];
  wire [4:0] wx = samp[0] ? {1'b0, fx} : FR_ONE - {1'b0, fx};
  wire [4:0] wy = samp[1] ? {1'b0, fy} : FR_ONE - {1'b0, fy};
  wire [9:0] sw = lin ? 10'(wx * wy) : scale ? SW_BOX : SW_FULL;
  wire [4:0] lw = !miplin ? LW_FULL :
    pass ? {1'b0, lod[3:0]} : LW_FULL - {1'b0, lod[3:0]};
  wire [12:0] weight = buf_msg ? W_FULL : 13'(sw * lw);
  wire last_samp = lin ? samp == LAST_BILIN :
    scale ? samp == LAST_SCALE : 1'b1;
  wire [5:0] n_tuples = BASE_TUPLES << cur.simd;
  wire last_tuple = tuple_cnt == n_tuples - 6'h01;

  // Per-channel shadow, gamma and weighted accumulation
  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [20:0] acc;
    wire [7:0] raw = texel[8*c +: 8];
    wire [7:0] shd = use_shadow ? {8{shadow_pass}} : raw;
    wire [15:0] sq = 16'(shd) * 16'(shd) + 16'(shd);
    wire [7:0] gc = (use_gamma && c < 3) ? sq[15:8] : shd;
    wire [20:0] prod = 21'(gc) * 21'(weight);
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        acc <= '0;
      end else if (state == ST_SETUP) begin
        acc <= '0;
      end else if (state == ST_ACC) begin
        acc <= acc + prod;
      end
    end
    assign rgba_w[8*c +: 8] = acc[WSHIFT +: 8];
  end

  tse_palette_ram #(.DW(32), .AW(PAL_AW)) u_pal (
    .clk_i(clk_i),
    .we_i(pal_we_i),
    .waddr_i(pal_addr_i),
    .wdata_i(pal_data_i),
    .raddr_i(pal_idx),
    .rdata_o(pal_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer; one access outstanding keeps returns in tuple order
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cur <= '0;
      ss <= '0;
      ss_valid <= 1'b0;
      ss_key <= '0;
      tuple_cnt <= '0;
      samp <= '0;
      pass <= 1'b0;
      lod <= '0;
      face <= '0;
      s_co <= '0;
      t_co <= '0;
      word <= '0;
      req_ready_o <= 1'b0;
      mem_req_valid_o <= 1'b0;
      mem_req_we_o <= 1'b0;
      mem_req_addr_o <= '0;
      mem_req_wdata_o <= '0;
      res_valid_o <= 1'b0;
      res_o <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            cur <= req_i;
            req_ready_o <= 1'b0;
            state <= need_ss ? ST_SS_REQ : ST_SETUP;
          end else begin
            req_ready_o <= 1'b1;
          end
        end
        ST_SS_REQ: begin
          if (!mem_req_valid_o) begin
            mem_req_valid_o <= 1'b1;
            mem_req_we_o <= 1'b0;
            mem_req_addr_o <= ss_addr;
          end else if (mem_req_ready_i) begin
            mem_req_valid_o <= 1'b0;
            state <= ST_SS_WAIT;
          end
        end
        ST_SS_WAIT: begin
          if (mem_rsp_valid_i) begin
            ss <= mem_rsp_data_i;
            ss_valid <= 1'b1;
            ss_key <= {cur.ss_ptr, cur.ss_idx};
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          s_co <= s_in;
          t_co <= t_in;
          face <= face_w;
          lod <= lod_in;
          samp <= '0;
          pass <= 1'b0;
          state <= ST_F_REQ;
        end
        ST_F_REQ: begin
          if (!mem_req_valid_o) begin
            mem_req_valid_o <= 1'b1;
            mem_req_we_o <= 1'b0;
            mem_req_addr_o <= fetch_addr;
          end else if (mem_req_ready_i) begin
            mem_req_valid_o <= 1'b0;
            state <= ST_F_WAIT;
          end
        end
        ST_F_WAIT: begin
          if (mem_rsp_valid_i) begin
            word <= mem_rsp_data_i;
            state <= (!buf_msg && cur.surf.fmt == FMT_PAL8) ?
              ST_PAL : ST_ACC;
          end
        end
        ST_PAL: begin
          state <= ST_ACC;
        end
        ST_ACC: begin
          if (!last_samp) begin
            samp <= samp + 6'h01;
            state <= ST_F_REQ;
          end else if (miplin && !pass) begin
            samp <= '0;
            pass <= 1'b1;
            state <= ST_F_REQ;
          end else begin
            state <= ST_OUT;
          end
        end
        ST_OUT: begin
          if (cur.rt_en) begin
            if (!mem_req_valid_o) begin
              mem_req_valid_o <= 1'b1;
              mem_req_we_o <= 1'b1;
              mem_req_addr_o <= rt_addr;
              mem_req_wdata_o <= rgba_w;
            end else if (mem_req_ready_i) begin
              mem_req_valid_o <= 1'b0;
              mem_req_we_o <= 1'b0;
              tuple_cnt <= last_tuple ? '0 : tuple_cnt + 6'h01;
              ss_valid <= ss_valid && !last_tuple;
              req_ready_o <= 1'b1;
              state <= ST_IDLE;
            end
          end else begin
            if (!res_valid_o) begin
              res_valid_o <= 1'b1;
              res_o.id <= cur.id;
              res_o.tuple <= tuple_cnt;
              res_o.subspan <= tuple_cnt[5:2];
              res_o.lane <= tuple_cnt[1:0];
              res_o.last <= last_tuple;
              res_o.rgba <= rgba_w;
            end else if (res_ready_i) begin
              res_valid_o <= 1'b0;
              tuple_cnt <= last_tuple ? '0 : tuple_cnt + 6'h01;
              ss_valid <= ss_valid && !last_tuple;
              req_ready_o <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ### tb/tse_mem_model.sv
// Memory partner of the sampler: random stalls, one read in flight
module tse_mem_model (
  input wire logic clk_i,               // Clock
  input wire logic resetn_i,            // Reset, active low
  input wire logic valid_i,             // Access offered
  output logic ready_o = 1'b0,          // Access taken
  input wire logic we_i,                // Write when high
  input wire logic [31:0] addr_i,       // Byte address
  input wire logic [31:0] cfg_i,        // Word of the config region
  output logic rsp_valid_o = 1'b0,      // Read data pulse
  output logic [31:0] rsp_data_o = 32'h0 // Read data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pend = 1'b0;
  logic [1:0] lag;
  logic [31:0] paddr;
  int cfg_cnt = 0;
  logic [31:0] cfg_last = 32'h0;

  // Upper half of the map holds filter configuration words
  function automatic logic [31:0] word(input logic [31:0] a);
    return a[31] ? cfg_i : (a ^ (a >> 13) ^ 32'hC3A55A3C);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      pend <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      // Idle data line toggles so a stale word never looks like an answer
      rsp_data_o <= ~rsp_data_o;
      ready_o <= valid_i && !ready_o && !pend &&
        ($urandom_range(0, 2) != 0);
      if (valid_i && ready_o && !we_i) begin
        pend <= 1'b1;
        paddr <= addr_i;
        lag <= 2'($urandom_range(0, 3));
      end
      if (pend && lag == 2'h0) begin
        pend <= 1'b0;
        rsp_valid_o <= 1'b1;
        rsp_data_o <= word(paddr);
        if (paddr[31]) begin
          cfg_cnt <= cfg_cnt + 1;
          cfg_last <= paddr;
        end
      end else if (pend) begin
        lag <= lag - 2'h1;
      end
    end
  end
endmodule

// ### tb/tse_sampler_monitor.sv
// Port checker of the texture sampling engine
module tse_sampler_monitor (
  input wire logic clk_i,                // Clock
  input wire logic resetn_i,             // Reset, active low
  input wire logic req_valid_i,          // Tuple offered
  input wire logic req_ready_o,          // Tuple taken
  input wire tse_pkg::tse_req_s req_i,   // Tuple
  input wire logic mem_req_valid_o,      // Memory access offered
  input wire logic mem_req_ready_i,      // Memory access taken
  input wire logic mem_req_we_o,         // Write when high
  input wire logic [31:0] mem_req_addr_o, // Byte address
  input wire logic res_valid_o,          // Result offered
  input wire logic res_ready_i,          // Result taken
  input wire tse_pkg::tse_res_s res_o    // Result
);
  timeunit 1ns;
  timeprecision 1ps;
  import tse_pkg::*;

  logic [ID_W-1:0] id_q;
  tse_simd_e simd_q;
  logic rt_q;
  wire logic take;
  wire logic [5:0] last_idx;

  assign take = req_valid_i && req_ready_o;
  // Sixty-four tuples wrap the shift to zero, so minus one gives 63
  assign last_idx = (6'h08 << simd_q) - 6'h01;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      id_q <= '0;
      simd_q <= SIMD8;
      rt_q <= 1'b0;
    end else if (take) begin
      id_q <= req_i.id;
      simd_q <= req_i.simd;
      rt_q <= req_i.rt_en;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  //////////////////////////////////////////////////////////////////////////
  a_ready_gap: assert property (take |=> !req_ready_o [*3])
    else $error("ready back too soon after a take");
  a_ready_late: assert property ($rose(resetn_i) |-> !req_ready_o [*2])
    else $error("ready too early after reset");
  a_res_hold: assert property (res_valid_o && !res_ready_i
    |=> res_valid_o && $stable(res_o))
    else $error("result changed while stalled");
  a_res_drop: assert property (res_valid_o && res_ready_i
    |=> !res_valid_o)
    else $error("result valid kept after take");
  a_mem_hold: assert property (mem_req_valid_o && !mem_req_ready_i
    |=> mem_req_valid_o && $stable(mem_req_addr_o) && $stable(mem_req_we_o))
    else $error("memory access changed while stalled");
  a_mem_drop: assert property (mem_req_valid_o && mem_req_ready_i
    |=> !mem_req_valid_o)
    else $error("memory valid kept after take");
  a_lane_split: assert property (res_valid_o |->
    res_o.subspan == res_o.tuple[5:2] && res_o.lane == res_o.tuple[1:0])
    else $error("subspan or lane wrong");
  a_last_flag: assert property (res_valid_o |->
    res_o.last == (res_o.tuple == last_idx))
    else $error("last flag wrong");
  a_res_tag: assert property (res_valid_o |-> res_o.id == id_q)
    else $error("result tagged with wrong requester");
  a_rt_quiet: assert property (rt_q |-> !res_valid_o)
    else $error("result beat for render target tuple");
  a_rt_write: assert property (mem_req_valid_o && mem_req_we_o |-> rt_q)
    else $error("memory write without render target");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |->
    !req_ready_o && !res_valid_o && !mem_req_valid_o)
    else $error("output active in reset");
endmodule

bind tse_sampler tse_sampler_monitor u_mon (
  .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .req_i(req_i),
  .mem_req_valid_o(mem_req_valid_o), .mem_req_ready_i(mem_req_ready_i),
  .mem_req_we_o(mem_req_we_o), .mem_req_addr_o(mem_req_addr_o),
  .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_o(res_o)
);

// ### tb/tb.sv
// Self-checking bench of the texture sampling engine
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tse_pkg::*;

  logic clk_i = 1'b0;
  logic resetn_i = 1'b1;
  logic req_valid_i = 1'b0;
  tse_req_s req_i = '0;
  logic pal_we_i = 1'b0;
  logic [7:0] pal_addr_i = 8'h00;
  logic [31:0] pal_data_i = 32'h0;
  logic res_ready_i = 1'b0;
  logic [31:0] cfg = 32'h0;
  logic req_ready_o, mem_req_valid_o, mem_req_ready_i, mem_req_we_o;
  logic mem_rsp_valid_i, res_valid_o;
  logic [31:0] mem_req_addr_o, mem_req_wdata_o, mem_rsp_data_i;
  tse_res_s res_o;
  wire logic wr_seen;
  int n_fail = 0;
  int n_tests = 0;
  int seed;

  assign wr_seen = (mem_req_valid_o & mem_req_ready_i & mem_req_we_o) === 1'b1;

  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) res_ready_i <= ($urandom_range(0, 3) != 0);

  tse_sampler u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i),
    .mem_req_valid_o(mem_req_valid_o), .mem_req_ready_i(mem_req_ready_i),
    .mem_req_we_o(mem_req_we_o), .mem_req_addr_o(mem_req_addr_o),
    .mem_req_wdata_o(mem_req_wdata_o), .mem_rsp_valid_i(mem_rsp_valid_i),
    .mem_rsp_data_i(mem_rsp_data_i), .pal_we_i(pal_we_i),
    .pal_addr_i(pal_addr_i), .pal_data_i(pal_data_i),
    .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_o(res_o)
  );

  tse_mem_model u_mem (
    .clk_i(clk_i), .resetn_i(resetn_i), .valid_i(mem_req_valid_o),
    .ready_o(mem_req_ready_i), .we_i(mem_req_we_o), .addr_i(mem_req_addr_o),
    .cfg_i(cfg), .rsp_valid_o(mem_rsp_valid_i), .rsp_data_o(mem_rsp_data_i)
  );

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pal(input logic [7:0] i);
    return {i, ~i, i ^ 8'h5A, 8'h3C};
  endfunction

  // Texture tests use texel (0,0); every tap lands there, so level and format decide
  function automatic logic [31:0] expect_rgba(input tse_req_s h);
    logic [31:0] w;
    logic [15:0] p;
    if (h.msg == MSG_BUF_LD)
      return u_mem.word(h.surf.base + {14'h0, h.u, 2'h0});
    w = u_mem.word(h.surf.base + 32'(h.lod[7:4]) * h.surf.mip_pitch);
    if (h.surf.fmt == FMT_PAL8) w = pal(w[7:0]);
    if (h.msg != MSG_SAMPLE) return w;
    if (cfg[SS_SHADOW]) return (w[7:0] <= h.r[15:8]) ? 32'hFFFFFFFF : 32'h0;
    if (cfg[SS_GAMMA]) begin
      for (int c = 0; c < 3; c++) begin
        p = 16'(w[c*8 +: 8]) * 16'(w[c*8 +: 8]) + 16'(w[c*8 +: 8]);
        w[c*8 +: 8] = p[15:8];
      end
    end
    return w;
  endfunction

  task automatic chk_res(input tse_res_s got, input tse_res_s exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: result %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Tuples go back to back with the header repeated; called at a clock edge
  task automatic run_msg(input tse_req_s h);
    tse_req_s t;
    tse_res_s e;
    int n;
    int k;
    n = 8 << h.simd;
    t = h;
    for (int i = 0; i < n; i++) begin
      if (h.msg == MSG_BUF_LD) t.u = 16'($urandom_range(0, 1023));
      req_i <= t;
      req_valid_i <= 1'b1;
      k = 0;
      do @(negedge clk_i); while (req_ready_o !== 1'b1 && ++k < 4000);
      @(posedge clk_i);
      if (i == n - 1) req_valid_i <= 1'b0;
      e = '{id: h.id, tuple: 6'(i), subspan: 4'(i >> 2), lane: 2'(i),
            last: (i == n - 1), rgba: expect_rgba(t)};
      do @(negedge clk_i);
      while (!(h.rt_en ? wr_seen : (res_valid_o === 1'b1 && res_ready_i))
             && ++k < 4000);
      if (k >= 4000) begin
        n_fail++;
        results();
      end
      if (h.rt_en) begin
        chk_word(mem_req_addr_o, h.rt_base + 32'(i) * 32'h4);
        chk_word(mem_req_wdata_o, e.rgba);
      end else begin
        chk_res(res_o, e);
      end
      @(posedge clk_i);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    tse_req_s h;
    int n;
    seed = $urandom(46);
    resetn_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 256; i++) begin
      @(posedge clk_i);
      pal_we_i <= 1'b1;
      pal_addr_i <= 8'(i);
      pal_data_i <= pal(8'(i));
    end
    @(posedge clk_i);
    pal_we_i <= 1'b0;
    h = '0;
    h.surf.base = 32'h00010000;
    h.surf.mip_pitch = 32'h00004000;
    h.surf.w_log2 = 4'h6;
    h.surf.h_log2 = 4'h6;
    h.ss_ptr = 32'h80000100;
    h.lod_given = 1'b1;
    h.rt_base = 32'h00020000;
    h.msg = MSG_BUF_LD;
    for (int s = 0; s < 4; s++) begin
      h.simd = tse_simd_e'(s);
      h.id = 4'($urandom);
      run_msg(h);
    end
    h.msg = MSG_SAMPLE;
    h.simd = SIMD8;
    for (int i = 0; i < 16; i++) begin
      h.ss_idx = 4'(i);
      h.lod = {4'($urandom_range(0, 3)), 4'h0};
      h.r = 16'($urandom);
      cfg = (32'h1 << SS_ADDRU) | (32'h1 << SS_ADDRV);
      // Bilinear taps clamp and mirror both fold onto texel (0,0); a zero
      // LOD fraction leaves the second level with no weight
      if (i % 4 == 3) cfg = cfg << 1;
      if (i % 4 == 0) cfg = cfg | (32'h1 << SS_FILT) | (32'h1 << SS_MIPLIN);
      if (i % 2 == 1) cfg = cfg | (32'h1 << SS_GAMMA);
      if (i % 4 == 2) cfg = cfg | (32'h1 << SS_SHADOW);
      run_msg(h);
      chk_word(u_mem.cfg_last, h.ss_ptr + 32'(i) * 32'h4);
    end
    h.msg = MSG_LD;
    h.simd = SIMD16;
    h.lod_given = 1'b0;
    h.grad = 16'h0040; // Four texels per pixel
    h.lod = 8'h20; // Level the bench expects, log2 of four
    n = u_mem.cfg_cnt;
    run_msg(h);
    chk_word(32'(u_mem.cfg_cnt), 32'(n));
    h.msg = MSG_SAMPLE;
    h.simd = SIMD8;
    cfg = (32'h1 << SS_ADDRU) | (32'h1 << SS_ADDRV);
    h.rt_en = 1'b1;
    run_msg(h);
    h.rt_en = 1'b0;
    h.lod_given = 1'b1;
    h.surf.fmt = FMT_PAL8;
    h.simd = SIMD16;
    h.lod = {4'($urandom_range(1, 3)), 4'h0};
    run_msg(h);
    results();
  end
endmodule
